/* dbgp_consts.vh */
// dbgp_consts.vh: register offsets, field positions and reset values of the port group
// assumes: included by bare name from the port design file
`ifndef DBGP_CONSTS_VH
`define DBGP_CONSTS_VH
// byte offsets within one group's register set
`define DBGP_OFF_DIR 12'h000
`define DBGP_OFF_DIRCLR 12'h004
`define DBGP_OFF_DIRSET 12'h008
`define DBGP_OFF_DIRTGL 12'h00c
`define DBGP_OFF_OUT 12'h010
`define DBGP_OFF_OUTPUT_CLEAR_REG 12'h014
`define DBGP_OFF_OUTPUT_SET_REG 12'h018
`define DBGP_OFF_OUTPUT_TOGGLE_REG 12'h01c
`define DBGP_OFF_IN 12'h020
`define DBGP_OFF_CTRL 12'h024
`define DBGP_OFF_PINCFG 12'h040
`define DBGP_OFF_PMUX 12'h030
`define DBGP_OFF_ANALOG 12'h038
`define DBGP_OFF_STATUS 12'h03c
`define DBGP_GROUP_STRIDE 12'h080
// local bus window base
`define DBGP_LB_BASE 32'h60000000
// reset values
`define DBGP_RST_ZERO 32'h00000000
// status field positions
`define DBGP_ST_PROT 0
`define DBGP_ST_DBG 1
// resynchronisation depth of the on-demand sampler
`define DBGP_SYNC_CYC 2'h2
// axi responses
`define DBGP_RESP_OKAY 2'h0
`define DBGP_RESP_SLVERR 2'h2
`endif

/* dbgp_port.v */
// dbgp_port.v: one gpio port group with axi4-lite (bridge side) and a single-cycle local bus
// assumes: one clock clk (cpu main clock); the bridge path is qualified by apb_tick from the clock divider
//
// Overview of operation
// - group of up to 32 individually driven lines
// - atomic set clear toggle, other pins untouched
// - local bus reaches direction, output, input only
// - pin index equals register bit position
// - peripheral owns pad output, reads pad level
// - reset makes all lines digital-off inputs
// - power-down keeps pad latches, loses configuration
// - keeps running while its clock runs
// - main clock local bus, divided clock bridge
// - local bus wins, bridge access waits
// - input synchronisers run on main clock
// - debug halt freezes nothing
// - protection blocks bridge writes, lifted in debug
// - external debugger writes always succeed
// - analog select disables digital pad features
// - local bus single cycle, byte half word
// - local bus base 0x60000000, same map
// - local bus set clear toggle, input read-only
// - direction one drives output value
// - ones in set clear toggle act
// - on-demand sampling delays read two cycles
// - per-byte sampling bit keeps synchronisers running
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dbgp_consts.vh"

module dbgp_port #(
	parameter NPINS = 32,
	parameter [31:0] IMPL_MASK = 32'hffffffff
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// bridge path pacing (divided clock enable), protection and debug
	input wire apb_tick,
	input wire prot_en,
	input wire cpu_halted,
	input wire ext_dbg,
	// power-down of the group
	input wire pwr_down,
	// axi4-lite slave
	input wire [31:0] s_awaddr,
	input wire s_awvalid,
	output reg s_awready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	input wire s_wvalid,
	output reg s_wready,
	output reg [1:0] s_bresp,
	output reg s_bvalid,
	input wire s_bready,
	input wire [31:0] s_araddr,
	input wire s_arvalid,
	output reg s_arready,
	output reg [31:0] s_rdata,
	output reg [1:0] s_rresp,
	output reg s_rvalid,
	input wire s_rready,
	// cpu local bus
	input wire lb_sel,
	input wire lb_write,
	input wire [31:0] lb_addr,
	input wire [1:0] lb_size,
	input wire [31:0] lb_wdata,
	output reg [31:0] lb_rdata,
	// pads
	input wire [NPINS-1:0] pad_in,
	output reg [NPINS-1:0] pad_out,
	output reg [NPINS-1:0] pad_oe_n,
	output reg [NPINS-1:0] pad_ie,
	output reg [NPINS-1:0] pad_pull_en,
	// peripheral takeover
	input wire [NPINS-1:0] per_out,
	input wire [NPINS-1:0] per_oe,
	output reg [NPINS-1:0] per_in
);

	// only the implemented lines of the group take part
	localparam [NPINS-1:0] MASK = IMPL_MASK[NPINS-1:0];
	localparam S_IDLE = 2'h0;
	localparam S_WAIT = 2'h1;
	localparam S_RESP = 2'h2;

	// --------------------------------------------------
	// helpers
	// --------------------------------------------------
	function [31:0] lane_mask;
		input [1:0] size;
		input [1:0] a;
		begin
			case (size)
				2'h0: lane_mask = 32'h000000ff << {a, 3'h0};
				2'h1: lane_mask = a[1] ? 32'hffff0000 : 32'h0000ffff;
				default: lane_mask = 32'hffffffff;
			endcase
		end
	endfunction

	function [31:0] strb_mask;
		input [3:0] s;
		begin
			strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		end
	endfunction

	// zero-extend a pin vector to a bus word; unimplemented bits read zero
	function [31:0] widen;
		input [NPINS-1:0] v;
		begin
			widen = 32'h0;
			widen[NPINS-1:0] = v;
		end
	endfunction

	// apply one write op to a direction or output register; only ones in the mask act
	function [NPINS-1:0] apply_op;
		input [NPINS-1:0] cur;
		input [1:0] op;
		input [NPINS-1:0] d;
		input [NPINS-1:0] m;
		begin
			case (op)
				2'h0: apply_op = (cur & ~m) | (d & m);
				2'h1: apply_op = cur & ~(d & m);
				2'h2: apply_op = cur | (d & m);
				default: apply_op = cur ^ (d & m);
			endcase
		end
	endfunction

	// --------------------------------------------------
	// state
	// --------------------------------------------------
	reg [NPINS-1:0] dir_r, dir_nxt;
	reg [NPINS-1:0] out_r, out_nxt;
	reg [NPINS-1:0] input_buffer_enable_r, pmux_en_r, pull_r, analog_r;
	reg [3:0] samp_r;
	reg [NPINS-1:0] sync1_r, sync2_r;
	reg [1:0] ax_state_r;
	reg [31:0] awaddr_r, araddr_r, wdata_r;
	reg [3:0] wstrb_r;
	reg aw_have_r, w_have_r, ar_pend_r;
	reg [1:0] rd_wait_r;
	reg [NPINS-1:0] pad_out_nxt, pad_oe_n_nxt, pad_ie_nxt, pad_pull_nxt, per_in_nxt;

	wire [11:0] lb_off = lb_addr[11:0];
	// compare only the window bits of the base so the widths match
	wire [31:0] lb_base = `DBGP_LB_BASE;
	wire lb_hit = lb_sel && (lb_addr[31:12] == lb_base[31:12]);
	wire lb_is_dio = (lb_off[11:5] == 7'h0);
	wire lb_wr = lb_hit && lb_write && lb_is_dio;
	// bridge writes blocked by protection unless halted or from the debugger
	wire wr_allowed = !prot_en || cpu_halted || ext_dbg;
	wire [11:0] aw_off = awaddr_r[11:0];
	wire [11:0] ar_off = araddr_r[11:0];
	// bridge access moves only on the divided tick and never beside a local access
	wire bus_go = apb_tick && !lb_hit;
	wire wr_go = aw_have_r && w_have_r && bus_go && ax_state_r == S_IDLE;
	wire [NPINS-1:0] wmask = strb_mask(wstrb_r) & MASK;
	wire [NPINS-1:0] lmask = lane_mask(lb_size, lb_addr[1:0]) & MASK;
	// only with every group sampling can a read skip the on-demand delay
	wire samp_all = &samp_r;
	wire [NPINS-1:0] samp_mask = {{8{samp_r[3]}}, {8{samp_r[2]}}, {8{samp_r[1]}}, {8{samp_r[0]}}};
	// a bridge read in flight clocks every synchroniser
	wire rd_demand = ar_pend_r || rd_wait_r != 2'h0;
	wire [NPINS-1:0] sync_run = samp_mask | {NPINS{rd_demand}};

	// --------------------------------------------------
	// direction and output next values
	// --------------------------------------------------
	always @* begin
		dir_nxt = dir_r;
		out_nxt = out_r;
		// local write takes the cycle; the bridge write waits for a cycle with no local access
		if (lb_wr) begin
			if (lb_off[4] == 1'b0)
				dir_nxt = apply_op(dir_r, lb_off[3:2], lb_wdata[NPINS-1:0], lmask);
			else
				out_nxt = apply_op(out_r, lb_off[3:2], lb_wdata[NPINS-1:0], lmask);
		end else if (wr_go && wr_allowed && aw_off[11:5] == 7'h0) begin
			if (aw_off[4] == 1'b0)
				dir_nxt = apply_op(dir_r, aw_off[3:2], wdata_r[NPINS-1:0], wmask);
			else
				out_nxt = apply_op(out_r, aw_off[3:2], wdata_r[NPINS-1:0], wmask);
		end
	end

	// --------------------------------------------------
	// registers and axi4-lite slave
	// --------------------------------------------------
	always @(posedge clk) begin
		if (rst || pwr_down) begin
			dir_r <= {NPINS{1'b0}};
			out_r <= {NPINS{1'b0}};
			input_buffer_enable_r <= {NPINS{1'b0}};
			pmux_en_r <= {NPINS{1'b0}};
			pull_r <= {NPINS{1'b0}};
			analog_r <= {NPINS{1'b0}};
			samp_r <= 4'h0;
			ax_state_r <= S_IDLE;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			ar_pend_r <= 1'b0;
			rd_wait_r <= 2'h0;
			awaddr_r <= `DBGP_RST_ZERO;
			araddr_r <= `DBGP_RST_ZERO;
			wdata_r <= `DBGP_RST_ZERO;
			wstrb_r <= 4'h0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_arready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= `DBGP_RESP_OKAY;
			s_rvalid <= 1'b0;
			s_rresp <= `DBGP_RESP_OKAY;
			s_rdata <= `DBGP_RST_ZERO;
			lb_rdata <= `DBGP_RST_ZERO;
		end else begin
			dir_r <= dir_nxt;
			out_r <= out_nxt;
			// local reads answer at the next edge and never stall
			if (lb_hit && !lb_write)
				lb_rdata <= lb_is_dio && !lb_off[4] ? widen(dir_r) :
					lb_is_dio ? widen(out_r) :
					(lb_off == `DBGP_OFF_IN) ? widen(sync2_r & input_buffer_enable_r & MASK) :
					`DBGP_RST_ZERO;
			// write address and data taken in either order
			s_awready <= !aw_have_r && s_awvalid && !s_awready;
			s_wready <= !w_have_r && s_wvalid && !s_wready;
			if (s_awvalid && s_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_have_r <= 1'b1;
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (aw_off > `DBGP_OFF_PINCFG) ? `DBGP_RESP_SLVERR : `DBGP_RESP_OKAY;
				if (wr_allowed) begin
					if (aw_off == `DBGP_OFF_CTRL)
						samp_r <= wdata_r[3:0] & {4{wstrb_r[0]}};
					if (aw_off == `DBGP_OFF_PMUX)
						pmux_en_r <= apply_op(pmux_en_r, 2'h0, wdata_r[NPINS-1:0], wmask);
					if (aw_off == `DBGP_OFF_PINCFG)
						input_buffer_enable_r <= apply_op(input_buffer_enable_r, 2'h0, wdata_r[NPINS-1:0], wmask);
					if (aw_off == `DBGP_OFF_ANALOG)
						analog_r <= apply_op(analog_r, 2'h0, wdata_r[NPINS-1:0], wmask);
					if (aw_off == `DBGP_OFF_STATUS)
						pull_r <= apply_op(pull_r, 2'h0, wdata_r[NPINS-1:0], wmask);
				end
			end
			if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
			// reads: on-demand sampling adds two cycles before data
			s_arready <= !ar_pend_r && !s_rvalid && s_arvalid && !s_arready;
			if (s_arvalid && s_arready) begin
				ar_pend_r <= 1'b1;
				araddr_r <= s_araddr;
				rd_wait_r <= samp_all ? 2'h0 : `DBGP_SYNC_CYC;
			end
			if (ar_pend_r && rd_wait_r != 2'h0)
				rd_wait_r <= rd_wait_r - 2'h1;
			if (ar_pend_r && rd_wait_r == 2'h0 && bus_go) begin
				ar_pend_r <= 1'b0;
				s_rvalid <= 1'b1;
				s_rresp <= (ar_off > `DBGP_OFF_PINCFG) ? `DBGP_RESP_SLVERR : `DBGP_RESP_OKAY;
				case (ar_off)
					`DBGP_OFF_DIR, `DBGP_OFF_DIRCLR, `DBGP_OFF_DIRSET, `DBGP_OFF_DIRTGL:
						s_rdata <= widen(dir_r);
					`DBGP_OFF_OUT, `DBGP_OFF_OUTPUT_CLEAR_REG, `DBGP_OFF_OUTPUT_SET_REG, `DBGP_OFF_OUTPUT_TOGGLE_REG:
						s_rdata <= widen(out_r);
					`DBGP_OFF_IN: s_rdata <= widen(sync2_r & input_buffer_enable_r & MASK);
					`DBGP_OFF_CTRL: s_rdata <= {28'h0, samp_r};
					`DBGP_OFF_PMUX: s_rdata <= widen(pmux_en_r);
					`DBGP_OFF_PINCFG: s_rdata <= widen(input_buffer_enable_r);
					`DBGP_OFF_ANALOG: s_rdata <= widen(analog_r);
					`DBGP_OFF_STATUS: s_rdata <= widen(pull_r);
					default: s_rdata <= `DBGP_RST_ZERO;
				endcase
			end
			if (s_rvalid && s_rready)
				s_rvalid <= 1'b0;
		end
	end

	// --------------------------------------------------
	// input synchronisers on the main clock
	// --------------------------------------------------
	// a line runs while its byte group samples or a bridge read waits; others hold
	always @(posedge clk) begin
		if (rst || pwr_down) begin
			sync1_r <= {NPINS{1'b0}};
			sync2_r <= {NPINS{1'b0}};
		end else begin
			sync1_r <= (pad_in & sync_run) | (sync1_r & ~sync_run);
			sync2_r <= (sync1_r & sync_run) | (sync2_r & ~sync_run);
		end
	end

	// --------------------------------------------------
	// pad drive next values
	// --------------------------------------------------
	always @* begin
		// peripheral takes the pad, analog removes all digital paths
		pad_out_nxt = ~analog_r & ((pmux_en_r & per_out) | (~pmux_en_r & out_r)) & MASK;
		pad_oe_n_nxt = ~(~analog_r & ((pmux_en_r & per_oe) | (~pmux_en_r & dir_r)) & MASK);
		pad_ie_nxt = ~analog_r & (input_buffer_enable_r | pmux_en_r) & MASK;
		// a direction bit of one switches the pull off
		pad_pull_nxt = ~analog_r & ~dir_r & pull_r & MASK;
		per_in_nxt = pmux_en_r & ~analog_r & pad_in;
	end

	// --------------------------------------------------
	// pad drive; debug halt freezes nothing here
	// --------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			pad_out <= {NPINS{1'b0}};
			pad_oe_n <= {NPINS{1'b1}};
			pad_ie <= {NPINS{1'b0}};
			pad_pull_en <= {NPINS{1'b0}};
			per_in <= {NPINS{1'b0}};
		end else if (!pwr_down) begin
			// pad latches hold their last state while the group is powered down
			pad_out <= pad_out_nxt;
			pad_oe_n <= pad_oe_n_nxt;
			pad_ie <= pad_ie_nxt;
			pad_pull_en <= pad_pull_nxt;
			per_in <= per_in_nxt;
		end
	end

endmodule // dbgp_port

/* dbgp_monitor.sv */
// dbgp_monitor.sv: pin and bus assertions for one port group
// assumes: bound into dbgp_port; one clock clk, rst synchronous active high
`timescale 1ns/1ps
`include "dbgp_consts.vh"
module dbgp_monitor #(
	parameter NPINS = 32
) (
	// clock, reset, power
	input wire clk,
	input wire rst,
	input wire pwr_down,
	// bridge handshakes
	input wire s_awready,
	input wire [1:0] s_bresp,
	input wire s_bvalid,
	input wire s_bready,
	input wire [31:0] s_rdata,
	input wire s_rvalid,
	input wire s_rready,
	// local bus
	input wire lb_sel,
	input wire lb_write,
	input wire [31:0] lb_addr,
	input wire [1:0] lb_size,
	input wire [31:0] lb_wdata,
	input wire [31:0] lb_rdata,
	// pads
	input wire [NPINS-1:0] pad_out,
	input wire [NPINS-1:0] pad_oe_n,
	input wire [NPINS-1:0] pad_ie,
	input wire [NPINS-1:0] pad_pull_en
);
	default clocking @(posedge clk); endclocking
	wire wr_word = lb_sel && lb_write && lb_size == 2'h2;
	wire rd_out = lb_sel && !lb_write && lb_addr == `DBGP_LB_BASE + `DBGP_OFF_OUT;
	wire rd_dir = lb_sel && !lb_write && lb_addr == `DBGP_LB_BASE + `DBGP_OFF_DIR;
	a_reset_idle: assert property (rst |=> &pad_oe_n && pad_ie == 0 && pad_pull_en == 0 && !s_bvalid)
		else $error("pads not idle after reset");
	a_pd_hold: assert property (disable iff (rst) pwr_down && $past(pwr_down) && !$past(rst) |-> $stable(pad_out))
		else $error("pad output moved in power-down");
	a_b_hold: assert property (disable iff (rst) s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (disable iff (rst) s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read data dropped");
	a_aw_pulse: assert property (disable iff (rst) s_awready |=> !s_awready)
		else $error("awready longer than one cycle");
	a_lb_output_set_reg: assert property (disable iff (rst) wr_word && lb_addr == `DBGP_LB_BASE + `DBGP_OFF_OUTPUT_SET_REG ##1 rd_out
		|=> (lb_rdata & $past(lb_wdata, 2)) == $past(lb_wdata, 2)) else $error("output set lost");
	a_lb_output_clear_reg: assert property (disable iff (rst) wr_word && lb_addr == `DBGP_LB_BASE + `DBGP_OFF_OUTPUT_CLEAR_REG ##1 rd_out
		|=> (lb_rdata & $past(lb_wdata, 2)) == 0) else $error("output clear lost");
	a_lb_dirset: assert property (disable iff (rst) wr_word && lb_addr == `DBGP_LB_BASE + `DBGP_OFF_DIRSET ##1 rd_dir
		|=> (lb_rdata & $past(lb_wdata, 2)) == $past(lb_wdata, 2)) else $error("direction set lost");
endmodule // dbgp_monitor

bind dbgp_port dbgp_monitor #(.NPINS(NPINS)) u_monitor (.clk(clk), .rst(rst), .pwr_down(pwr_down),
	.s_awready(s_awready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_rdata(s_rdata),
	.s_rvalid(s_rvalid), .s_rready(s_rready), .lb_sel(lb_sel), .lb_write(lb_write), .lb_addr(lb_addr),
	.lb_size(lb_size), .lb_wdata(lb_wdata), .lb_rdata(lb_rdata), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
	.pad_ie(pad_ie), .pad_pull_en(pad_pull_en));

/* dbgp_pads.sv */
// dbgp_pads.sv: pad wires and outside drivers facing one port group
// assumes: ext_en and ext_val come from the bench
`timescale 1ns/1ps
module dbgp_pads #(
	parameter NPINS = 32
) (
	// clock
	input wire clk,
	// port side
	input wire [NPINS-1:0] pad_out,
	input wire [NPINS-1:0] pad_oe_n,
	input wire [NPINS-1:0] pad_pull_en,
	// outside drivers
	input wire [NPINS-1:0] ext_en,
	input wire [NPINS-1:0] ext_val,
	// level on the wire
	output wire [NPINS-1:0] pad_in
);
	logic [NPINS-1:0] float_r = '0;
	wire [NPINS-1:0] free_w = pad_oe_n & ~ext_en;
	// undriven lines without pull wander every cycle
	always @(posedge clk) float_r <= ~float_r;
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
		| (free_w & pad_pull_en & pad_out) | (free_w & ~pad_pull_en & float_r);
endmodule // dbgp_pads

/* dbgp_tb.sv */
// dbgp_tb.sv: self-checking bench for one port group
// assumes: dbgp_port, dbgp_pads and dbgp_monitor compiled first
`timescale 1ns/1ps
`include "dbgp_consts.vh"
module testbench;
	logic clk, rst, apb_tick, prot_en, cpu_halted, ext_dbg, pwr_down, lb_sel, lb_write;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
	logic [1:0] s_bresp, s_rresp, lb_size, resp, sz;
	logic [3:0] s_wstrb;
	logic [11:0] o, ro;
	logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, lb_addr, lb_wdata, lb_rdata, rd, d, e;
	logic [31:0] pad_in, pad_out, pad_oe_n, pad_ie, pad_pull_en, per_in, ext_en, ext_val;
	logic [89:0] tab [7];
	int n_errors = 0;
	int checks_done = 0;
	dbgp_port i_dut (.clk(clk), .rst(rst), .apb_tick(apb_tick), .prot_en(prot_en), .cpu_halted(cpu_halted),
		.ext_dbg(ext_dbg), .pwr_down(pwr_down), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
		.s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .lb_sel(lb_sel),
		.lb_write(lb_write), .lb_addr(lb_addr), .lb_size(lb_size), .lb_wdata(lb_wdata), .lb_rdata(lb_rdata),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_ie(pad_ie), .pad_pull_en(pad_pull_en),
		.per_out(32'h0), .per_oe(32'h0), .per_in(per_in));
	dbgp_pads i_pads (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) apb_tick <= !rst && !apb_tick;
	initial begin
		#300000;
		n_errors++;
		summarize;
	end
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input string what, input [31:0] seen, input [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// local bus cycle, left selected so a read may follow at once
	task lb(input w, input [11:0] off, input [31:0] dat, input [1:0] size);
		lb_sel <= 1;
		lb_write <= w;
		lb_addr <= `DBGP_LB_BASE + off;
		lb_wdata <= dat;
		lb_size <= size;
		@(posedge clk);
	endtask
	task lbr(input [11:0] off, output [31:0] v);
		lb(0, off, 0, 2'h2);
		lb_sel <= 0;
		@(posedge clk);
		v = lb_rdata;
	endtask
	task axw(input [11:0] off, input [31:0] dat);
		s_awaddr <= off;
		s_wdata <= dat;
		s_wstrb <= 4'hf;
		s_awvalid <= 1;
		s_wvalid <= 1;
		do begin
			@(posedge clk);
			if (s_awready) s_awvalid <= 0;
			if (s_wready) s_wvalid <= 0;
		end while (s_bvalid !== 1'b1);
		s_bready <= 1;
		@(posedge clk);
		resp = s_bresp;
		s_bready <= 0;
		@(posedge clk);
	endtask
	task axr(input [11:0] off, output [31:0] v);
		s_araddr <= off;
		s_arvalid <= 1;
		do begin
			@(posedge clk);
			if (s_arready) s_arvalid <= 0;
		end while (s_rvalid !== 1'b1);
		s_rready <= 1;
		@(posedge clk);
		v = s_rdata;
		resp = s_rresp;
		s_rready <= 0;
		@(posedge clk);
	endtask
	initial begin
		{rst, prot_en, cpu_halted, ext_dbg, pwr_down, lb_sel, lb_write} = 7'h40;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, lb_size, s_wstrb} = 11'h0;
		{s_awaddr, s_wdata, s_araddr, lb_addr, lb_wdata, ext_en, ext_val} = 224'h0;
		tab = '{{`DBGP_OFF_DIR, 2'h2, 32'h0000ffff, `DBGP_OFF_DIR, 32'h0000ffff},
			{`DBGP_OFF_OUTPUT_SET_REG, 2'h2, 32'h0f0f0f0f, `DBGP_OFF_OUT, 32'h0f0f0f0f},
			{`DBGP_OFF_OUTPUT_CLEAR_REG, 2'h2, 32'h0000000f, `DBGP_OFF_OUT, 32'h0f0f0f00},
			{`DBGP_OFF_OUTPUT_TOGGLE_REG, 2'h2, 32'hff000000, `DBGP_OFF_OUT, 32'hf00f0f00},
			{`DBGP_OFF_DIRTGL, 2'h0, 32'h5a5a5a5a, `DBGP_OFF_DIR, 32'h0000ffa5},
			{`DBGP_OFF_DIRCLR, 2'h1, 32'h00ff00ff, `DBGP_OFF_DIR, 32'h0000ff00},
			{`DBGP_OFF_DIRSET, 2'h2, 32'h00000003, `DBGP_OFF_DIR, 32'h0000ff03}};
		repeat (12) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk("oe_n", pad_oe_n, 32'hffffffff);
		chk("ie", pad_ie | pad_pull_en, 32'h0);
		for (int i = 0; i < 7; i++) begin
			{o, sz, d, ro, e} = tab[i];
			lb(1, o, d, sz);
			lbr(ro, rd);
			chk("lb reg", rd, e);
		end
		chk("oe_n", pad_oe_n, 32'hffff00fc);
		chk("pad out", pad_out & 32'h0000ff03, 32'h00000f00);
		$display("test local bus done");
		axw(`DBGP_OFF_OUT, 32'h12345678);
		lbr(`DBGP_OFF_OUT, rd);
		chk("shared out", rd, 32'h12345678);
		axr(12'h07c, rd);
		chk("unmapped", {rd[31:2], resp}, {30'h0, `DBGP_RESP_SLVERR});
		prot_en <= 1;
		for (int i = 0; i < 3; i++) begin
			cpu_halted <= i == 1;
			ext_dbg <= i == 2;
			axw(`DBGP_OFF_OUT, i + 1);
			lbr(`DBGP_OFF_OUT, rd);
			chk("protect", rd, i == 0 ? 32'h12345678 : i + 1);
		end
		{prot_en, cpu_halted, ext_dbg} <= 3'h0;
		$display("test bridge done");
		ext_en <= 32'hffffffff;
		ext_val <= 32'ha5a5c3c3;
		axw(`DBGP_OFF_PINCFG, 32'hffffffff);
		axw(`DBGP_OFF_DIR, 32'h0);
		axr(`DBGP_OFF_IN, rd);
		chk("in on demand", rd, 32'ha5a5c3c3);
		axw(`DBGP_OFF_CTRL, 32'hf);
		ext_val <= 32'h3c3c5a5a;
		repeat (3) @(posedge clk);
		lbr(`DBGP_OFF_IN, rd);
		chk("in sampled", rd, 32'h3c3c5a5a);
		axw(`DBGP_OFF_CTRL, 32'h1);
		ext_val <= 32'hffffffff;
		repeat (3) @(posedge clk);
		lbr(`DBGP_OFF_IN, rd);
		chk("in group", rd, 32'h3c3c5aff);
		axw(`DBGP_OFF_DIR, 32'h000000ff);
		axw(`DBGP_OFF_ANALOG, 32'h1);
		chk("analog", {pad_oe_n[0], pad_ie[0], pad_pull_en[0]}, 3'h4);
		fork
			axw(`DBGP_OFF_OUT, 32'ha5);
			begin
				repeat (4) lb(1, `DBGP_OFF_OUT, 32'h1, 2'h2);
				lb_sel <= 0;
			end
		join
		lbr(`DBGP_OFF_OUT, rd);
		chk("collide", rd, 32'ha5);
		pwr_down <= 1;
		repeat (4) @(posedge clk);
		chk("held pad", pad_out & 32'hfe, 32'ha4);
		pwr_down <= 0;
		@(posedge clk);
		lbr(`DBGP_OFF_DIR, rd);
		chk("lost dir", rd, 32'h0);
		axw(`DBGP_OFF_DIR, 32'h0);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk("oe_n again", pad_oe_n, 32'hffffffff);
		$display("test power and reset done");
		summarize;
	end
endmodule // testbench
